/* File: rtl/pdk_params.svh */
`ifndef PDK_PARAMS_SVH
`define PDK_PARAMS_SVH

// register offsets
`define PDK_ADDR_LANG 8'h00
`define PDK_ADDR_MODE 8'h04
`define PDK_ADDR_STEP 8'h08
`define PDK_ADDR_BUZZ 8'h0c
`define PDK_ADDR_CONTRAST 8'h10
`define PDK_ADDR_MAXFREQ 8'h14
`define PDK_ADDR_UGROUP 8'h18
`define PDK_ADDR_WPROT 8'h1c
`define PDK_ADDR_SPEEDSEL 8'h20
`define PDK_ADDR_SETFREQ 8'h24
`define PDK_ADDR_STATUS 8'h28

// reset values
`define PDK_RST_LANG 3'h0
`define PDK_RST_MODE 4'h0
`define PDK_RST_STEP 3'h0
`define PDK_RST_BUZZ 1'h1
`define PDK_RST_CONTRAST 6'h3a
`define PDK_RST_MAXFREQ 20'h02ee0
`define PDK_RST_UGROUP 8'h00
`define PDK_RST_WPROT 2'h0
`define PDK_RST_SPEEDSEL 1'h0

// panel mode codes
`define PDK_MODE_DIAL 4'h0
`define PDK_MODE_POT 4'h1
`define PDK_MODE_DIAL_LK 4'ha
`define PDK_MODE_POT_LK 4'hb

// step sizes in 0.01 units, indexed by step code 0..4
`define PDK_STEP_MAXCODE 3'h4
`define PDK_STEP_0P01 20'h00001
`define PDK_STEP_0P10 20'h0000a
`define PDK_STEP_1P00 20'h00064
`define PDK_STEP_10P0 20'h003e8

// resolution thresholds (0.01 units)
`define PDK_COARSE_FREQ 20'h02710
`define PDK_COARSE_SPEED 20'h186a0

`define PDK_DIAL_CLICKS 5'h18

// status field positions
`define PDK_ST_LOCKED 0
`define PDK_ST_DISP 1
`define PDK_ST_PEND 3
`define PDK_ST_POS 8

// timing
`define PDK_CLK_HZ 64'd250000000
`define PDK_HOLD_S 64'd2
`define PDK_IDLE_S 64'd2
`define PDK_NVM_S 64'd10
`define PDK_HOLD_CYC (`PDK_HOLD_S * `PDK_CLK_HZ)
`define PDK_IDLE_CYC (`PDK_IDLE_S * `PDK_CLK_HZ)
`define PDK_NVM_CYC (`PDK_NVM_S * `PDK_CLK_HZ)

`endif

/* File: rtl/pdk_pkg.sv */
package pdk_pkg;
  typedef enum logic [1:0] {
    PDK_DISP_MON = 2'b00,
    PDK_DISP_LOCK = 2'b01,
    PDK_DISP_REJ = 2'b10
  } pdk_disp_t;
endpackage

/* File: rtl/pdk_tmr_if.sv */
`timescale 1ns/10ps
interface pdk_tmr_if;
  logic run;
  logic clr;
  logic expired;
  modport owner (output run, output clr, input expired);
  modport timer (input run, input clr, output expired);
endinterface

/* File: rtl/pdk_hold_timer.sv */
`timescale 1ns/10ps
// counts cycles while run is high; expired stays high from LIMIT until run drops or clr is raised
module pdk_hold_timer #(
  parameter logic [31:0] LIMIT = 32'h0000_0010
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  pdk_tmr_if.timer t
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic exp_r;

  always_comb begin
    if (t.clr || !t.run) begin
      cnt_nxt = 32'h0;
    end else if (cnt_r == LIMIT) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 32'h0;
      exp_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      exp_r <= (cnt_nxt == LIMIT);
    end
  end

  assign t.expired = exp_r;

  a_timer_reach: assert property (@(posedge clk_sys) disable iff (reset)
    exp_r |-> (cnt_r == LIMIT)) else $error("timer expired before its limit");
endmodule

/* File: rtl/pdk_panel_ctrl.sv */
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "pdk_params.svh"
// Functional notes
// - language code 0..7, reset 0
// - mode 0,1,10,11; lock allowed at 10/11
// - potentiometer mode: dial updates frequency immediately
// - store changed frequency after 10s
// - mode key 2s locks dial and keys
// - mode key 2s again unlocks
// - lock/reject indication, monitor after 2s idle
// - stop key and monitor work while locked
// - dial raise clamps at maximum frequency
// - step code zero gives 0.01 per click
// - step codes give 0.01/0.10/1.00/10.00 below value 100
// - dial rotation is 24 clicks
// - value 100 or more: step at least 0.1
// - speed value 1000 or more: step at least 1
// - configured step only for set frequency
// - buzzer enable beeps on unit key press
// - enabled buzzer also sounds on fault
// - contrast 0..63, reset 58
// - settings writable only when user group 0; the user group and write protect registers here are writable in any group
// - step/buzzer/contrast writable while running
module pdk_panel_ctrl
  import pdk_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = 32'(`PDK_HOLD_CYC),
  parameter logic [31:0] IDLE_CYCLES = 32'(`PDK_IDLE_CYC),
  parameter logic [31:0] NVM_CYCLES = 32'(`PDK_NVM_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_r,
  input wire logic dial_cw,
  input wire logic dial_ccw,
  input wire logic key_mode,
  input wire logic key_set,
  input wire logic key_other,
  input wire logic key_stop,
  input wire logic key_pu,
  input wire logic drive_fault,
  input wire logic motor_running,
  input wire logic edit_set_freq,
  output logic [19:0] set_freq_r,
  output logic [19:0] pend_freq_r,
  output logic nvm_we_r,
  output logic [19:0] nvm_data_r,
  output logic locked_r,
  output pdk_disp_t disp_r,
  output logic stop_cmd_r,
  output logic beep_r,
  output logic param_inc_r,
  output logic param_dec_r,
  output logic [4:0] dial_pos_r,
  output logic [2:0] display_language_select_r,
  output logic [5:0] lcd_contrast_level_r
);
  logic [3:0] dial_mode_lock_select_r;
  logic [2:0] dial_step_size_r;
  logic buzzer_enable_r;
  logic [19:0] max_frequency_limit_r;
  logic [7:0] user_group_read_select_r;
  logic [1:0] write_protect_select_r;
  logic machine_speed_display_select_r;
  logic nvm_pend_r;
  logic hold_used_r;
  logic fault_d_r;

  pdk_tmr_if hold_t ();
  pdk_tmr_if idle_t ();
  pdk_tmr_if nvm_t ();

  logic pot_mode;
  logic lock_ok;
  logic grp_ok;
  logic run_ok;
  logic dial_act;
  logic dial_up;
  logic touch;
  logic tog;
  logic wr_set;
  logic [19:0] base_val;
  logic [19:0] step;
  logic [19:0] dial_val;
  logic [20:0] sum;

  assign pot_mode = (dial_mode_lock_select_r == `PDK_MODE_POT) ||
                    (dial_mode_lock_select_r == `PDK_MODE_POT_LK);
  assign lock_ok = (dial_mode_lock_select_r == `PDK_MODE_DIAL_LK) ||
                   (dial_mode_lock_select_r == `PDK_MODE_POT_LK);
  assign grp_ok = (user_group_read_select_r == 8'h00);
  assign run_ok = !motor_running || (write_protect_select_r != 2'h0);
  assign dial_act = (dial_cw ^ dial_ccw) && !locked_r;
  assign dial_up = dial_cw;
  assign touch = dial_cw || dial_ccw || key_set || key_other;
  assign tog = lock_ok && hold_t.expired && !hold_used_r;
  assign wr_set = edit_set_freq && ((dial_act && pot_mode) ||
                  (key_set && !locked_r && !pot_mode));
  assign base_val = pot_mode ? set_freq_r : pend_freq_r;

  // step per click, widened to the display resolution
  always_comb begin
    case (dial_step_size_r)
      3'h2: step = `PDK_STEP_0P10;
      3'h3: step = `PDK_STEP_1P00;
      3'h4: step = `PDK_STEP_10P0;
      default: step = `PDK_STEP_0P01;
    endcase
    if (base_val >= `PDK_COARSE_FREQ && step < `PDK_STEP_0P10) begin
      step = `PDK_STEP_0P10;
    end
    if (machine_speed_display_select_r && base_val >= `PDK_COARSE_SPEED && step < `PDK_STEP_1P00) begin
      step = `PDK_STEP_1P00;
    end
  end

  always_comb begin
    sum = {1'b0, base_val} + {1'b0, step};
    if (dial_up) begin
      if (sum > {1'b0, max_frequency_limit_r}) begin
        dial_val = max_frequency_limit_r;
      end else begin
        dial_val = sum[19:0];
      end
    end else if (base_val < step) begin
      dial_val = 20'h0;
    end else begin
      dial_val = base_val - step;
    end
  end

  // register writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      display_language_select_r <= `PDK_RST_LANG;
      dial_mode_lock_select_r <= `PDK_RST_MODE;
      dial_step_size_r <= `PDK_RST_STEP;
      buzzer_enable_r <= `PDK_RST_BUZZ;
      lcd_contrast_level_r <= `PDK_RST_CONTRAST;
      max_frequency_limit_r <= `PDK_RST_MAXFREQ;
      user_group_read_select_r <= `PDK_RST_UGROUP;
      write_protect_select_r <= `PDK_RST_WPROT;
      machine_speed_display_select_r <= `PDK_RST_SPEEDSEL;
    end else if (ce && wr) begin
      case (addr)
        `PDK_ADDR_LANG: if (grp_ok && run_ok) begin
          display_language_select_r <= wdata[2:0];
        end
        `PDK_ADDR_MODE: if (grp_ok && run_ok && (wdata[31:4] == 28'h0) &&
                            (wdata[3:0] == `PDK_MODE_DIAL || wdata[3:0] == `PDK_MODE_POT ||
                             wdata[3:0] == `PDK_MODE_DIAL_LK || wdata[3:0] == `PDK_MODE_POT_LK)) begin
          dial_mode_lock_select_r <= wdata[3:0];
        end
        `PDK_ADDR_STEP: if (grp_ok && wdata[31:3] == 29'h0 && wdata[2:0] <= `PDK_STEP_MAXCODE) begin
          dial_step_size_r <= wdata[2:0];
        end
        `PDK_ADDR_BUZZ: if (grp_ok) begin
          buzzer_enable_r <= wdata[0];
        end
        `PDK_ADDR_CONTRAST: if (grp_ok) begin
          lcd_contrast_level_r <= wdata[5:0];
        end
        `PDK_ADDR_MAXFREQ: if (grp_ok && run_ok) begin
          max_frequency_limit_r <= wdata[19:0];
        end
        `PDK_ADDR_UGROUP: begin
          user_group_read_select_r <= wdata[7:0];
        end
        `PDK_ADDR_WPROT: begin
          write_protect_select_r <= wdata[1:0];
        end
        `PDK_ADDR_SPEEDSEL: if (grp_ok && run_ok) begin
          machine_speed_display_select_r <= wdata[0];
        end
        default: begin
        end
      endcase
    end
  end

  // register reads, one cycle later; unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= 32'h0;
    end else if (ce) begin
      rdata_r <= 32'h0;
      if (rd) begin
        case (addr)
          `PDK_ADDR_LANG: rdata_r <= {29'h0, display_language_select_r};
          `PDK_ADDR_MODE: rdata_r <= {28'h0, dial_mode_lock_select_r};
          `PDK_ADDR_STEP: rdata_r <= {29'h0, dial_step_size_r};
          `PDK_ADDR_BUZZ: rdata_r <= {31'h0, buzzer_enable_r};
          `PDK_ADDR_CONTRAST: rdata_r <= {26'h0, lcd_contrast_level_r};
          `PDK_ADDR_MAXFREQ: rdata_r <= {12'h0, max_frequency_limit_r};
          `PDK_ADDR_UGROUP: rdata_r <= {24'h0, user_group_read_select_r};
          `PDK_ADDR_WPROT: rdata_r <= {30'h0, write_protect_select_r};
          `PDK_ADDR_SPEEDSEL: rdata_r <= {31'h0, machine_speed_display_select_r};
          `PDK_ADDR_SETFREQ: rdata_r <= {12'h0, set_freq_r};
          `PDK_ADDR_STATUS: rdata_r <= {19'h0, dial_pos_r, 4'h0, nvm_pend_r, disp_r, locked_r};
          default: rdata_r <= 32'h0;
        endcase
      end
    end
  end

  // set frequency and direct-mode pending value
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      set_freq_r <= 20'h0;
      pend_freq_r <= 20'h0;
    end else if (ce) begin
      if (wr_set) begin
        set_freq_r <= pot_mode ? dial_val : pend_freq_r;
      end
      if (edit_set_freq && dial_act && !pot_mode) begin
        pend_freq_r <= dial_val;
      end else if (!edit_set_freq || pot_mode) begin
        pend_freq_r <= set_freq_r;
      end
    end
  end

  // other frequency parameters get plain single-step pulses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      param_inc_r <= 1'b0;
      param_dec_r <= 1'b0;
    end else if (ce) begin
      param_inc_r <= dial_act && !edit_set_freq && dial_cw;
      param_dec_r <= dial_act && !edit_set_freq && dial_ccw;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dial_pos_r <= 5'h0;
    end else if (ce && dial_act) begin
      if (dial_cw) begin
        dial_pos_r <= (dial_pos_r == `PDK_DIAL_CLICKS - 5'h1) ? 5'h0 : dial_pos_r + 5'h1;
      end else begin
        dial_pos_r <= (dial_pos_r == 5'h0) ? `PDK_DIAL_CLICKS - 5'h1 : dial_pos_r - 5'h1;
      end
    end
  end

  // delayed store to nonvolatile memory; a new change restarts the delay
  assign nvm_t.run = nvm_pend_r;
  assign nvm_t.clr = wr_set;
  pdk_hold_timer #(.LIMIT(NVM_CYCLES)) u_nvm_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .t(nvm_t)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nvm_pend_r <= 1'b0;
      nvm_we_r <= 1'b0;
      nvm_data_r <= 20'h0;
    end else if (ce) begin
      nvm_we_r <= 1'b0;
      if (wr_set) begin
        nvm_pend_r <= 1'b1;
      end else if (nvm_pend_r && nvm_t.expired) begin
        nvm_pend_r <= 1'b0;
        nvm_we_r <= 1'b1;
        nvm_data_r <= set_freq_r;
      end
    end
  end

  // long press of the mode key
  assign hold_t.run = key_mode && lock_ok;
  assign hold_t.clr = !key_mode;
  pdk_hold_timer #(.LIMIT(HOLD_CYCLES)) u_hold_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .t(hold_t)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_used_r <= 1'b0;
      locked_r <= 1'b0;
    end else if (ce) begin
      hold_used_r <= key_mode && (hold_used_r || hold_t.expired);
      if (!lock_ok) begin
        locked_r <= 1'b0;
      end else if (tog) begin
        locked_r <= !locked_r;
      end
    end
  end

  // panel display: lock and reject fall back to monitor after idle time
  assign idle_t.run = (disp_r != PDK_DISP_MON);
  assign idle_t.clr = tog || (locked_r && touch);
  pdk_hold_timer #(.LIMIT(IDLE_CYCLES)) u_idle_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .t(idle_t)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      disp_r <= PDK_DISP_MON;
    end else if (ce) begin
      if (tog) begin
        disp_r <= locked_r ? PDK_DISP_MON : PDK_DISP_LOCK;
      end else if (locked_r && touch) begin
        disp_r <= PDK_DISP_REJ;
      end else if (idle_t.expired) begin
        disp_r <= PDK_DISP_MON;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stop_cmd_r <= 1'b0;
      beep_r <= 1'b0;
      fault_d_r <= 1'b0;
    end else if (ce) begin
      stop_cmd_r <= key_stop;
      fault_d_r <= drive_fault;
      beep_r <= buzzer_enable_r && (key_pu || (drive_fault && !fault_d_r));
    end
  end

  a_lock_needs_mode: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(locked_r) |-> $past(lock_ok)) else $error("lock entered in a mode without lock");
  a_locked_freq_hold: assert property (@(posedge clk_sys) disable iff (reset)
    locked_r |=> $stable(set_freq_r)) else $error("set frequency moved while locked");
  a_stop_passes: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && key_stop) |=> stop_cmd_r) else $error("stop key not forwarded");
  a_max_clamp: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && wr_set && pot_mode && dial_cw && !dial_ccw) |=> (set_freq_r <= $past(max_frequency_limit_r)))
    else $error("dial raised frequency above maximum");
  a_floor_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && wr_set && pot_mode && dial_ccw && !dial_cw && set_freq_r < step) |=> (set_freq_r == 20'h0))
    else $error("dial down did not saturate at zero");
  a_pot_immediate: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && edit_set_freq && pot_mode && !locked_r && dial_cw && !dial_ccw &&
     set_freq_r < max_frequency_limit_r) |=> $changed(set_freq_r)) else $error("potentiometer dial not applied");
  a_step_fine: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && wr_set && pot_mode && dial_cw && !dial_ccw && dial_step_size_r == 3'h0 &&
     set_freq_r < 20'h02700 && set_freq_r < max_frequency_limit_r) |=> (set_freq_r == $past(set_freq_r) + 20'h1))
    else $error("default step is not one hundredth");
  a_nvm_after_pend: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(nvm_we_r) |-> ($past(nvm_pend_r) && !nvm_pend_r)) else $error("store without pending change");
  a_beep_key: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && key_pu) |=> (beep_r == $past(buzzer_enable_r))) else $error("beep does not follow enable");
  a_grp_block: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && wr && addr == `PDK_ADDR_CONTRAST && user_group_read_select_r != 8'h00) |=> $stable(lcd_contrast_level_r))
    else $error("write accepted outside user group 0");
endmodule

/* File: verif/pdk_operator.sv */
`timescale 1ns/10ps
// the person at the panel: every change lands just after a rising edge
module pdk_operator (
  input wire logic clk_sys,
  output logic dial_cw,
  output logic dial_ccw,
  output logic key_mode,
  output logic key_set,
  output logic key_other,
  output logic key_stop,
  output logic key_pu
);
  initial begin
    {dial_cw, dial_ccw, key_mode, key_set, key_other, key_stop, key_pu} = '0;
  end

  // n one-cycle clicks, gap+1 idle cycles after each; slow hands use a larger gap
  task automatic turn(input logic up, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      dial_cw <= up;
      dial_ccw <= !up;
      @(posedge clk_sys);
      dial_cw <= 1'b0;
      dial_ccw <= 1'b0;
      repeat (gap) @(posedge clk_sys);
    end
  endtask

  task automatic hold_mode(input int cyc);
    @(posedge clk_sys);
    key_mode <= 1'b1;
    repeat (cyc) @(posedge clk_sys);
    key_mode <= 1'b0;
  endtask

  // one-cycle press: 0 confirm, 1 other, 2 stop, 3 unit key
  task automatic tap(input int k);
    @(posedge clk_sys);
    case (k)
      0: key_set <= 1'b1;
      1: key_other <= 1'b1;
      2: key_stop <= 1'b1;
      default: key_pu <= 1'b1;
    endcase
    @(posedge clk_sys);
    {key_set, key_other, key_stop, key_pu} <= '0;
  endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/10ps
module tb
  import pdk_pkg::*;
;
  localparam int HOLD = 20;
  localparam int IDLE = 20;
  localparam int NVM = 50;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata_r;
  logic dial_cw, dial_ccw, key_mode, key_set, key_other, key_stop, key_pu;
  logic drive_fault = 1'b0;
  logic motor_running = 1'b0;
  logic edit_set_freq = 1'b1;
  logic [19:0] set_freq_r, nvm_data_r;
  logic nvm_we_r, stop_cmd_r, beep_r, param_inc_r;
  logic [19:0] pend_o;
  logic lk_o, dec_o;
  logic [4:0] pos_o;
  logic [2:0] lang_o;
  logic [5:0] con_o;
  pdk_disp_t disp_r;
  int n_fail = 0;
  int comparisons = 0;
  int beeps = 0;
  int incs = 0;
  int decs = 0;
  int d;
  int pos = 0;
  int k, b, c;
  logic [63:0] q[$];
  logic [31:0] rv[12] = '{0, 0, 0, 1, 32'h3a, 32'h2ee0, 0, 0, 0, 0, 0, 0};
  logic [31:0] steps[5] = '{32'h1, 32'h1, 32'ha, 32'h64, 32'h3e8};
  logic [31:0] modes[4] = '{32'h0, 32'h1, 32'ha, 32'hb};

  always #2 clk_sys = ~clk_sys;

  pdk_operator op (.clk_sys, .dial_cw, .dial_ccw, .key_mode, .key_set, .key_other, .key_stop, .key_pu);

  pdk_panel_ctrl #(.HOLD_CYCLES(32'(HOLD)), .IDLE_CYCLES(32'(IDLE)), .NVM_CYCLES(32'(NVM))) uut (
    .clk_sys, .reset, .ce, .addr, .wdata, .wr, .rd, .rdata_r, .dial_cw, .dial_ccw, .key_mode, .key_set,
    .key_other, .key_stop, .key_pu, .drive_fault, .motor_running, .edit_set_freq, .set_freq_r,
    .pend_freq_r(pend_o), .nvm_we_r, .nvm_data_r, .locked_r(lk_o), .disp_r, .stop_cmd_r, .beep_r,
    .param_inc_r, .param_dec_r(dec_o), .dial_pos_r(pos_o), .display_language_select_r(lang_o),
    .lcd_contrast_level_r(con_o));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe; the oldest note is its expectation
  always @(posedge clk_sys) begin
    if (rd_seen && q.size() > 0) begin
      check("read data", rdata_r & q[0][63:32], q[0][31:0]);
      void'(q.pop_front());
    end
    rd_seen <= rd;
    if (beep_r === 1'b1) beeps++;
    if (param_inc_r === 1'b1) incs++;
    if (dec_o === 1'b1) decs++;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    q.push_back({m, e & m});
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  // status word as expected: position, display, lock flag; store-pending bit left out
  function automatic logic [31:0] st(input logic lk, input logic [1:0] d);
    return (32'(pos) << 8) | (32'(d) << 1) | 32'(lk);
  endfunction

  task automatic spin(input logic up, input int n);
    op.turn(up, n, $urandom_range(2));
    pos = (pos + 240 + (up ? n : -n)) % 24;
  endtask

  initial begin
    void'($urandom(90380));
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++) rd_reg(8'(i * 4), rv[i]);
    check("contrast output", 32'(con_o), 32'h3a);
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h00, 32'(i));
      rd_reg(8'h00, 32'(i));
    end
    check("language output", 32'(lang_o), 32'h7);
    ce <= 1'b0;
    wr_reg(8'h00, 32'h3);
    ce <= 1'b1;
    rd_reg(8'h00, 32'h7);
    motor_running <= 1'b1;
    c = $urandom_range(63);
    wr_reg(8'h10, 32'(c));
    rd_reg(8'h10, 32'(c));
    check("contrast output", 32'(con_o), 32'(c));
    wr_reg(8'h08, 32'h3);
    rd_reg(8'h08, 32'h3);
    wr_reg(8'h0c, 32'h0);
    rd_reg(8'h0c, 32'h0);
    wr_reg(8'h00, 32'h2);
    rd_reg(8'h00, 32'h7);
    motor_running <= 1'b0;
    wr_reg(8'h18, 32'h1);
    wr_reg(8'h10, 32'(c ^ 1));
    rd_reg(8'h10, 32'(c));
    wr_reg(8'h18, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h04, modes[i]);
      rd_reg(8'h04, modes[i]);
    end
    wr_reg(8'h04, 32'h5);
    rd_reg(8'h04, 32'hb);
    b = beeps;
    op.tap(3);
    wr_reg(8'h0c, 32'h1);
    op.tap(3);
    drive_fault <= 1'b1;
    repeat (4) @(posedge clk_sys);
    drive_fault <= 1'b0;
    check("beep count", 32'(beeps - b), 32'h2);
    wr_reg(8'h04, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h08, 32'(i));
      spin(1'b1, 1);
      rd_reg(8'h24, steps[i]);
      spin(1'b0, 2);
      rd_reg(8'h24, 32'h0);
    end
    spin(1'b1, 13);
    rd_reg(8'h24, 32'h2ee0);
    wr_reg(8'h08, 32'h1);
    spin(1'b0, 1);
    rd_reg(8'h24, 32'h2ed6);
    wr_reg(8'h14, 32'h30d40);
    wr_reg(8'h20, 32'h1);
    wr_reg(8'h08, 32'h4);
    spin(1'b1, 89);
    wr_reg(8'h08, 32'h1);
    spin(1'b1, 1);
    rd_reg(8'h24, 32'h18ae2);
    rd_reg(8'h28, st(1'b0, 2'b00), 32'h1f07);
    check("dial position", 32'(pos_o), 32'(pos));
    wr_reg(8'h20, 32'h0);
    wr_reg(8'h08, 32'h4);
    spin(1'b0, 102);
    rd_reg(8'h24, 32'h0);
    wr_reg(8'h08, 32'h2);
    spin(1'b1, 1);
    for (k = 0; k < NVM + 20 && nvm_we_r !== 1'b1; k++) @(negedge clk_sys);
    check("store delay", 32'(k >= NVM - 2 && k <= NVM + 10), 32'h1);
    check("stored value", 32'(nvm_data_r), 32'ha);
    if (k == NVM + 20) results();
    @(posedge clk_sys);
    edit_set_freq <= 1'b0;
    b = incs;
    d = decs;
    spin(1'b1, 1);
    spin(1'b0, 1);
    rd_reg(8'h24, 32'ha);
    check("other step count", 32'(incs - b), 32'h1);
    check("other step down count", 32'(decs - d), 32'h1);
    edit_set_freq <= 1'b1;
    wr_reg(8'h04, 32'hb);
    op.hold_mode(HOLD + 4);
    repeat (2) @(posedge clk_sys);
    rd_reg(8'h28, st(1'b1, 2'b01), 32'h1f07);
    check("lock output", 32'(lk_o), 32'h1);
    op.turn(1'b1, 1, 0);
    rd_reg(8'h24, 32'ha);
    rd_reg(8'h28, st(1'b1, 2'b10), 32'h1f07);
    op.tap(2);
    @(negedge clk_sys);
    check("stop while locked", 32'(stop_cmd_r), 32'h1);
    repeat (IDLE + 6) @(posedge clk_sys);
    rd_reg(8'h28, st(1'b1, 2'b00), 32'h1f07);
    op.hold_mode(HOLD + 4);
    repeat (2) @(posedge clk_sys);
    rd_reg(8'h28, st(1'b0, 2'b00), 32'h1f01);
    check("lock output", 32'(lk_o), 32'h0);
    spin(1'b1, 1);
    rd_reg(8'h24, 32'h14);
    wr_reg(8'h04, 32'h0);
    op.hold_mode(HOLD + 4);
    rd_reg(8'h28, st(1'b0, 2'b00), 32'h1f01);
    spin(1'b1, 1);
    op.tap(1);
    rd_reg(8'h24, 32'h14);
    check("pending value", 32'(pend_o), 32'h1e);
    op.tap(0);
    rd_reg(8'h24, 32'h1e);
    repeat (4) @(posedge clk_sys);
    check("pending reads", 32'(q.size()), 32'h0);
    results();
  end
endmodule
